// >>> pkg/bscan_pkg.sv
package bscan_pkg;
	localparam int BSR_LEN = 67;
	localparam int IR_LEN = 4;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 17;
	localparam int MISC_W = 28;
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_SAMPLE = 4'h1;
	localparam logic [3:0] IR_RUNBIST = 4'h7;
	localparam logic [3:0] IR_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam int MEM_POS [8] = '{7, 5, 3, 1, 6, 4, 2, 0};
	localparam int HOST_POS [8] = '{31, 35, 32, 36, 30, 33, 34, 37};
	localparam int MBE_POS = 18;
	localparam int ADDR_POS = 45;
	localparam int DIR_MEM_LO = 62;
	localparam int DIR_MEM_HI = 63;
	localparam int DIR_MBE = 64;
	localparam int DIR_HOST_LO = 65;
	localparam int DIR_HOST_HI = 66;
	localparam logic [66:0] UPD_RST = {5'h1f, 62'h0};
	localparam int TMS_RESET_EDGES = 5;
	localparam int BIST_CYCLES = 960000;
	localparam int CHAIN_DEPTH = 67;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_BIST_CNT = 8'h08;
	localparam int CTRL_BIST_EN = 0;
	localparam logic CTRL_BIST_EN_RST = 1'h1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_PASS = 2;
	localparam int ST_EXTEST = 3;
	localparam int ST_RUNBIST = 4;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR,
		UPD_DR, SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} tap_state_t;
endpackage

// >>> pkg/tap_if.sv
`timescale 1ns/1ns
interface tap_if;
	logic tlr, rti, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir;
	modport ctrl (output tlr, rti, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
	modport user (input tlr, rti, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
endinterface

// >>> hw/tap_ctrl.sv
`timescale 1ns/1ns
module tap_ctrl (
	input wire logic tck, // Test clock.
	input wire logic tap_rst_n, // Asynchronous test reset, low active.
	input wire logic tms, // Test mode select.
	tap_if.ctrl tap // State decodes.
);
	bscan_pkg::tap_state_t st;
	bscan_pkg::tap_state_t next_st;
	logic [2:0] hi_cnt;

	always_comb begin
		unique case (st)
			bscan_pkg::TLR: next_st = tms ? bscan_pkg::TLR : bscan_pkg::RTI;
			bscan_pkg::RTI: next_st = tms ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
			bscan_pkg::SEL_DR: next_st = tms ? bscan_pkg::SEL_IR : bscan_pkg::CAP_DR;
			bscan_pkg::CAP_DR: next_st = tms ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
			bscan_pkg::SH_DR: next_st = tms ? bscan_pkg::EX1_DR : bscan_pkg::SH_DR;
			bscan_pkg::EX1_DR: next_st = tms ? bscan_pkg::UPD_DR : bscan_pkg::PA_DR;
			bscan_pkg::PA_DR: next_st = tms ? bscan_pkg::EX2_DR : bscan_pkg::PA_DR;
			bscan_pkg::EX2_DR: next_st = tms ? bscan_pkg::UPD_DR : bscan_pkg::SH_DR;
			bscan_pkg::UPD_DR: next_st = tms ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
			bscan_pkg::SEL_IR: next_st = tms ? bscan_pkg::TLR : bscan_pkg::CAP_IR;
			bscan_pkg::CAP_IR: next_st = tms ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
			bscan_pkg::SH_IR: next_st = tms ? bscan_pkg::EX1_IR : bscan_pkg::SH_IR;
			bscan_pkg::EX1_IR: next_st = tms ? bscan_pkg::UPD_IR : bscan_pkg::PA_IR;
			bscan_pkg::PA_IR: next_st = tms ? bscan_pkg::EX2_IR : bscan_pkg::PA_IR;
			bscan_pkg::EX2_IR: next_st = tms ? bscan_pkg::UPD_IR : bscan_pkg::SH_IR;
			bscan_pkg::UPD_IR: next_st = tms ? bscan_pkg::SEL_DR : bscan_pkg::RTI;
		endcase
	end

	// Every state reaches TLR within five edges of TMS high, so no counter is needed for it.
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			st <= bscan_pkg::TLR;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			hi_cnt <= 3'h0;
		end else if (!tms) begin
			hi_cnt <= 3'h0;
		end else if (hi_cnt != 3'h7) begin
			hi_cnt <= hi_cnt + 3'h1;
		end
	end

	assign tap.tlr = st == bscan_pkg::TLR;
	assign tap.rti = st == bscan_pkg::RTI;
	assign tap.cap_dr = st == bscan_pkg::CAP_DR;
	assign tap.sh_dr = st == bscan_pkg::SH_DR;
	assign tap.upd_dr = st == bscan_pkg::UPD_DR;
	assign tap.cap_ir = st == bscan_pkg::CAP_IR;
	assign tap.sh_ir = st == bscan_pkg::SH_IR;
	assign tap.upd_ir = st == bscan_pkg::UPD_IR;

	property p_tms_reset;
		@(posedge tck) disable iff (!tap_rst_n)
		(hi_cnt >= 3'(bscan_pkg::TMS_RESET_EDGES)) |-> st == bscan_pkg::TLR;
	endproperty
	a_tms_reset: assert property (p_tms_reset) else $error("TMS high five edges without reset");
endmodule

// >>> hw/bist_engine.sv
`timescale 1ns/1ns
module bist_engine #(
	parameter int CYCLES = bscan_pkg::BIST_CYCLES
) (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, low active.
	input wire logic start, // Level: run while high.
	output logic busy, // Test running.
	output logic done, // Test finished, held until start falls.
	output logic pass, // No mismatch seen.
	output logic [31:0] count // Cycles run so far.
);
	logic [7:0] mem [16];
	logic [7:0] pattern;

	assign pattern = {count[3:0], ~count[3:0]} ^ {8{count[5]}};

	// The array is walked in 16-word write and read halves for the whole run.
	always_ff @(posedge clk) begin
		if (busy && !count[4]) begin
			mem[count[3:0]] <= pattern;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !start) begin
			busy <= 1'b0;
			done <= 1'b0;
			pass <= 1'b1;
			count <= 32'h0;
		end else if (!busy && !done) begin
			busy <= 1'b1;
		end else if (busy) begin
			if (count[4] && mem[count[3:0]] != pattern) begin
				pass <= 1'b0;
			end
			if (count == 32'(CYCLES - 1)) begin
				busy <= 1'b0;
				done <= 1'b1;
			end
			count <= count + 32'h1;
		end
	end

	sequence s_launch;
		$rose(busy);
	endsequence
	sequence s_last;
		busy && count == 32'(CYCLES - 1);
	endsequence
	property p_run_holds;
		@(posedge clk) disable iff (!rst_n) s_launch |-> (busy && !done)[*8];
	endproperty
	property p_run_length;
		@(posedge clk) disable iff (!rst_n) s_last |=> done && !busy && count == 32'(CYCLES);
	endproperty
	a_run_holds: assert property (p_run_holds) else $error("Self test ended early");
	a_run_length: assert property (p_run_length) else $error("Self test length wrong");
endmodule

// >>> hw/cache_sram_boundary_scan.sv
// How it works
// - A 67-cell boundary register sits serially between test input and test output.
// - Cell order runs memory data, controls, host data, more controls, address 0-16, five direction cells.
// - A direction cell holding one tristates its pins or makes them inputs.
// - Memory data bits 0-3 and 4-7 each have their own direction cell.
// - Host data bits 0-3 and 4-7 each have their own direction cell.
// - The byte-enable/parity pin has one dedicated direction cell.
// - Self test runs about 960K clocks; the companion controller needs about 490K.
// - Asserting the test reset forces the TAP controller to Test-Logic-Reset.
// - Power-up puts the TAP controller in Test-Logic-Reset with test logic disabled.
// - Five rising test clock edges with TMS high reach Test-Logic-Reset.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
module cache_sram_boundary_scan #(
	parameter int BIST_CYCLES = bscan_pkg::BIST_CYCLES
) (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, low active.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size, word only.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Always OKAY.
	output logic [31:0] hrdata, // Read data.
	input wire logic tck, // Test clock.
	input wire logic trst_n, // Test reset, low active.
	input wire logic tms, // Test mode select.
	input wire logic tdi, // Test data in.
	output logic tdo, // Test data out.
	output logic tdo_oe, // Test data out enable.
	input wire logic [7:0] memory_bus_data_in, // Memory data pins, input.
	output logic [7:0] memory_bus_data_out, // Memory data pins, output.
	output logic [7:0] memory_bus_data_oe, // Memory data pins, enable.
	input wire logic [7:0] core_mem_data_out, // Core memory data to drive.
	input wire logic [7:0] core_mem_data_oe, // Core memory data enable.
	input wire logic [7:0] host_side_data_in, // Host data pins, input.
	output logic [7:0] host_side_data_out, // Host data pins, output.
	output logic [7:0] host_side_data_oe, // Host data pins, enable.
	input wire logic [7:0] core_host_data_out, // Core host data to drive.
	input wire logic [7:0] core_host_data_oe, // Core host data enable.
	input wire logic memory_byte_enable_parity_in, // Byte-enable/parity pin, input.
	output logic memory_byte_enable_parity_out, // Byte-enable/parity pin, output.
	output logic memory_byte_enable_parity_oe, // Byte-enable/parity pin, enable.
	input wire logic core_mbe_out, // Core byte-enable/parity value.
	input wire logic core_mbe_oe, // Core byte-enable/parity enable.
	input wire logic [16:0] addr_pin_in, // Address pins, observed.
	input wire logic [27:0] misc_pin_in // Control, clock and reset pins, observed.
);
	localparam int N = bscan_pkg::BSR_LEN;

	tap_if tap ();
	logic tap_rst_n;
	logic [3:0] ir;
	logic [3:0] ir_sh;
	logic [N-1:0] bsr;
	logic [N-1:0] upd;
	logic [N-1:0] raw;
	logic [N-1:0] cap_s1;
	logic [N-1:0] cap_s2;
	logic byp;
	logic tdr;
	logic sel_bsr;
	logic extest;
	logic runbist;
	logic dn_s1, dn_s2, ps_s1, ps_s2;
	logic rb_s1, rb_s2, ex_s1, ex_s2;
	logic bist_en;
	logic busy, done, pass;
	logic [31:0] bist_cnt;
	logic [31:0] status;
	logic wr_pend;
	logic [31:0] wr_addr;
	logic [6:0] sh_run;

	// Power-up reset is taken from the system reset as well, so the TAP is parked
	// even when the test master never pulses its own reset.
	assign tap_rst_n = trst_n & rst_n;

	tap_ctrl u_tap (
		.tck(tck),
		.tap_rst_n(tap_rst_n),
		.tms(tms),
		.tap(tap.ctrl)
	);

	bist_engine #(
		.CYCLES(BIST_CYCLES)
	) u_bist (
		.clk(clk),
		.rst_n(rst_n),
		.start(rb_s2 & bist_en),
		.busy(busy),
		.done(done),
		.pass(pass),
		.count(bist_cnt)
	);

	function automatic int misc_pos(input int i);
		return i < 10 ? 8 + i : (i < 21 ? 9 + i : 17 + i);
	endfunction

	function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
		return a[31:8] == 24'h0 && a[7:0] == off;
	endfunction

	assign sel_bsr = ir == bscan_pkg::IR_EXTEST || ir == bscan_pkg::IR_SAMPLE;
	assign extest = ir == bscan_pkg::IR_EXTEST;
	assign runbist = ir == bscan_pkg::IR_RUNBIST;

	// Instruction register; TLR falls back to bypass so the pins belong to the core.
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir <= bscan_pkg::IR_BYPASS;
			ir_sh <= bscan_pkg::IR_CAPTURE;
		end else if (tap.tlr) begin
			ir <= bscan_pkg::IR_BYPASS;
		end else if (tap.cap_ir) begin
			ir_sh <= bscan_pkg::IR_CAPTURE;
		end else if (tap.sh_ir) begin
			ir_sh <= {tdi, ir_sh[3:1]};
		end else if (tap.upd_ir) begin
			ir <= ir_sh;
		end
	end

	always_comb begin
		raw = '0;
		for (int i = 0; i < bscan_pkg::DATA_W; i++) begin
			raw[bscan_pkg::MEM_POS[i]] = memory_bus_data_in[i];
			raw[bscan_pkg::HOST_POS[i]] = host_side_data_in[i];
		end
		for (int i = 0; i < bscan_pkg::ADDR_W; i++) begin
			raw[bscan_pkg::ADDR_POS + i] = addr_pin_in[i];
		end
		for (int i = 0; i < bscan_pkg::MISC_W; i++) begin
			raw[misc_pos(i)] = misc_pin_in[i];
		end
		raw[bscan_pkg::MBE_POS] = memory_byte_enable_parity_in;
		raw[N-1:bscan_pkg::DIR_MEM_LO] = upd[N-1:bscan_pkg::DIR_MEM_LO];
	end

	// Pins are asynchronous to the test clock, so they are synchronised before capture.
	always_ff @(posedge tck) begin
		cap_s1 <= raw;
		cap_s2 <= cap_s1;
	end

	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsr <= '0;
		end else if (sel_bsr && tap.cap_dr) begin
			bsr <= cap_s2;
		end else if (sel_bsr && tap.sh_dr) begin
			bsr <= {bsr[N-2:0], tdi};
		end
	end

	// Direction cells reset to one so every governed pin is tristated if EXTEST is loaded before any update.
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			upd <= bscan_pkg::UPD_RST;
		end else if (sel_bsr && tap.upd_dr) begin
			upd <= bsr;
		end
	end

	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			byp <= 1'b0;
			tdr <= 1'b0;
		end else if (tap.cap_dr) begin
			byp <= 1'b0;
			tdr <= dn_s2 & ps_s2;
		end else if (tap.sh_dr) begin
			byp <= tdi;
			tdr <= tdi;
		end
	end

	// Test data out changes on the falling edge so the master samples it half a period later.
	always_ff @(negedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo_oe <= tap.sh_ir | tap.sh_dr;
			if (tap.sh_ir) begin
				tdo <= ir_sh[0];
			end else if (sel_bsr) begin
				tdo <= bsr[N-1];
			end else if (runbist) begin
				tdo <= tdr;
			end else begin
				tdo <= byp;
			end
		end
	end

	// Done and pass are frozen once done rises, so two separate level syncs are safe.
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			dn_s1 <= 1'b0;
			dn_s2 <= 1'b0;
			ps_s1 <= 1'b0;
			ps_s2 <= 1'b0;
		end else begin
			dn_s1 <= done;
			dn_s2 <= dn_s1;
			ps_s1 <= pass;
			ps_s2 <= ps_s1;
		end
	end

	generate
		for (genvar i = 0; i < bscan_pkg::DATA_W; i++) begin : g_pin
			localparam int MD = i < 4 ? bscan_pkg::DIR_MEM_LO : bscan_pkg::DIR_MEM_HI;
			localparam int HD = i < 4 ? bscan_pkg::DIR_HOST_LO : bscan_pkg::DIR_HOST_HI;
			assign memory_bus_data_out[i] = extest ? upd[bscan_pkg::MEM_POS[i]] : core_mem_data_out[i];
			assign memory_bus_data_oe[i] = extest ? ~upd[MD] : core_mem_data_oe[i];
			assign host_side_data_out[i] = extest ? upd[bscan_pkg::HOST_POS[i]] : core_host_data_out[i];
			assign host_side_data_oe[i] = extest ? ~upd[HD] : core_host_data_oe[i];
		end
	endgenerate

	assign memory_byte_enable_parity_out = extest ? upd[bscan_pkg::MBE_POS] : core_mbe_out;
	assign memory_byte_enable_parity_oe = extest ? ~upd[bscan_pkg::DIR_MBE] : core_mbe_oe;

	// Self-test request: a level held for as long as RUNBIST is the instruction.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
			ex_s1 <= 1'b0;
			ex_s2 <= 1'b0;
		end else begin
			rb_s1 <= runbist;
			rb_s2 <= rb_s1;
			ex_s1 <= extest;
			ex_s2 <= ex_s1;
		end
	end

	always_comb begin
		status = 32'h0;
		status[bscan_pkg::ST_BUSY] = busy;
		status[bscan_pkg::ST_DONE] = done;
		status[bscan_pkg::ST_PASS] = pass;
		status[bscan_pkg::ST_EXTEST] = ex_s2;
		status[bscan_pkg::ST_RUNBIST] = rb_s2;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			wr_addr <= haddr;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bist_en <= bscan_pkg::CTRL_BIST_EN_RST;
		end else if (wr_pend && hit(wr_addr, bscan_pkg::REG_CTRL)) begin
			bist_en <= hwdata[bscan_pkg::CTRL_BIST_EN];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (hit(haddr, bscan_pkg::REG_CTRL)) begin
				hrdata <= {31'h0, bist_en};
			end else if (hit(haddr, bscan_pkg::REG_STATUS)) begin
				hrdata <= status;
			end else if (hit(haddr, bscan_pkg::REG_BIST_CNT)) begin
				hrdata <= bist_cnt;
			end else begin
				hrdata <= 32'h0;
			end
		end
	end

	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			sh_run <= 7'h0;
		end else if (!(sel_bsr && tap.sh_dr)) begin
			sh_run <= 7'h0;
		end else if (sh_run != 7'h7f) begin
			sh_run <= sh_run + 7'h1;
		end
	end

	property p_trst;
		@(posedge tck) disable iff (!rst_n) $rose(trst_n) |-> tap.tlr && ir == bscan_pkg::IR_BYPASS;
	endproperty
	property p_powerup;
		@(posedge tck) disable iff (!trst_n) $rose(rst_n) |-> tap.tlr && !extest;
	endproperty
	property p_chain;
		@(posedge tck) disable iff (!tap_rst_n) (sh_run >= 7'h43) |-> bsr[N-1] == $past(tdi, 67);
	endproperty
	property p_order;
		@(posedge tck) disable iff (!tap_rst_n)
		(sel_bsr && tap.cap_dr) |=> bsr[0] == $past(memory_bus_data_in[7], 3)
			&& bsr[7] == $past(memory_bus_data_in[0], 3) && bsr[30] == $past(host_side_data_in[4], 3)
			&& bsr[37] == $past(host_side_data_in[7], 3) && bsr[61] == $past(addr_pin_in[16], 3);
	endproperty
	property p_mem_dir;
		@(posedge tck) disable iff (!tap_rst_n)
		extest |-> memory_bus_data_oe == {{4{~upd[63]}}, {4{~upd[62]}}};
	endproperty
	property p_mem_drive;
		@(posedge tck) disable iff (!tap_rst_n)
		(extest && !upd[63]) |-> memory_bus_data_out[7] == upd[0] && memory_bus_data_out[4] == upd[6];
	endproperty
	property p_host_dir;
		@(posedge tck) disable iff (!tap_rst_n)
		extest |-> host_side_data_oe == {{4{~upd[66]}}, {4{~upd[65]}}};
	endproperty
	property p_mbe_dir;
		@(posedge tck) disable iff (!tap_rst_n) (extest && upd[64]) |-> !memory_byte_enable_parity_oe;
	endproperty
	a_trst: assert property (p_trst) else $error("Test reset did not park the TAP");
	a_powerup: assert property (p_powerup) else $error("Power-up left TAP active");
	a_chain: assert property (p_chain) else $error("Boundary chain length wrong");
	a_order: assert property (p_order) else $error("Boundary cell order wrong");
	a_mem_dir: assert property (p_mem_dir) else $error("Memory data direction wrong");
	a_mem_drive: assert property (p_mem_drive) else $error("Memory data not driven from cells");
	a_host_dir: assert property (p_host_dir) else $error("Host data direction wrong");
	a_mbe_dir: assert property (p_mbe_dir) else $error("Byte-enable pin not tristated");
endmodule

// >>> dv/jtag_master.sv
`timescale 1ns/1ns
module jtag_master (
	output logic tck, // Test clock, still between frames.
	output logic tms, // Mode select.
	output logic tdi, // Serial data to the device.
	output logic trst_n, // Test reset, low active.
	input wire logic tdo // Serial data from the device.
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b1;
	end
	// One 6 ns period; tdo is taken just before the rising edge that moves the chain on.
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#3;
		q = tdo;
		tck = 1'b1;
		#3;
		tck = 1'b0;
	endtask
	task automatic reset5();
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
	// The reset is held across one test clock edge so the TAP sees it while clocked.
	task automatic pulse_trst();
		logic q;
		trst_n = 1'b0;
		tick(1'b0, 1'b0, q);
		trst_n = 1'b1;
		tick(1'b0, 1'b0, q);
	endtask
	// Starts and ends in Run-Test/Idle; din[n-1] goes in first, the first bit out lands in dout[n-1].
	// The idle ticks give the two-flop pin synchronisers time before the capture.
	task automatic scan(input logic ir, input int n, input logic [74:0] din, output logic [74:0] dout);
		logic q;
		dout = '0;
		repeat (3) tick(1'b0, 1'b0, q);
		tick(1'b1, 1'b0, q);
		if (ir) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int k = 0; k < n; k++) begin
			tick(k == n - 1, din[n - 1 - k], q);
			dout = {dout[73:0], q};
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	localparam int BIST_N = 200;
	logic clk;
	logic rst_n = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp;
	logic [31:0] hrdata, rd;
	logic tck, trst_n, tms, tdi, tdo, tdo_oe, tq;
	logic [7:0] mem_in = 8'h0, mem_out, mem_oe, cm_out = 8'h0, cm_oe = 8'h0;
	logic [7:0] host_in = 8'h0, host_out, host_oe, ch_out = 8'h0, ch_oe = 8'h0;
	logic mbe_in = 1'b0, mbe_out, mbe_oe, cb_out = 1'b0, cb_oe = 1'b0;
	logic [16:0] addr_in = 17'h0;
	logic [27:0] misc_in = 28'h0;
	logic [74:0] dout;
	logic [4:0] d;
	logic [4:0] dirs [4] = '{5'h1f, 5'h05, 5'h1a, 5'h00};
	int mem_ord [8] = '{7, 3, 6, 2, 5, 1, 4, 0};
	int host_ord [8] = '{4, 0, 2, 5, 6, 1, 3, 7};
	int n_errors = 0;
	int total_checks = 0;

	cache_sram_boundary_scan #(.BIST_CYCLES(BIST_N)) cache_sram_boundary_scan_inst (
		.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.memory_bus_data_in(mem_in), .memory_bus_data_out(mem_out), .memory_bus_data_oe(mem_oe),
		.core_mem_data_out(cm_out), .core_mem_data_oe(cm_oe), .host_side_data_in(host_in),
		.host_side_data_out(host_out), .host_side_data_oe(host_oe), .core_host_data_out(ch_out),
		.core_host_data_oe(ch_oe), .memory_byte_enable_parity_in(mbe_in),
		.memory_byte_enable_parity_out(mbe_out), .memory_byte_enable_parity_oe(mbe_oe),
		.core_mbe_out(cb_out), .core_mbe_oe(cb_oe), .addr_pin_in(addr_in), .misc_pin_in(misc_in)
	);
	// A released test data output floats to its pull-up level.
	jtag_master jtag_master_inst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_oe ? tdo : 1'b1));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [66:0] seen, input logic [66:0] want);
		total_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Single word transfer; a stuck ready is left to the watchdog.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check(hresp, 1'b0);
	endtask
	task automatic st();
		ahb(1'b0, bscan_pkg::REG_STATUS, 32'h0);
	endtask
	task automatic ir(input logic [3:0] c);
		jtag_master_inst.scan(1'b1, 4, {71'h0, c[0], c[1], c[2], c[3]}, dout);
	endtask
	task automatic check_core();
		@(posedge clk);
		check({mem_out, mem_oe, host_out, host_oe}, {cm_out, cm_oe, ch_out, ch_oe});
		check({mbe_out, mbe_oe}, {cb_out, cb_oe});
	endtask
	function automatic logic [66:0] cells(input logic [7:0] m, input logic [7:0] h, input logic b,
			input logic [16:0] a, input logic [27:0] x, input logic [4:0] dc);
		logic [66:0] v;
		v = '0;
		for (int j = 0; j < 8; j++) begin
			v[j] = m[mem_ord[j]];
			v[30 + j] = h[host_ord[j]];
		end
		for (int i = 0; i < 28; i++) begin
			v[i < 10 ? 8 + i : (i < 21 ? 9 + i : 17 + i)] = x[i];
		end
		v[18] = b;
		v[61:45] = a;
		v[66:62] = dc;
		return v;
	endfunction

	initial begin
		#200000;
		n_errors++;
		give_verdict();
	end

	initial begin
		repeat (11) @(posedge clk);
		// The test clock runs across the release so the power-up park is seen while clocked.
		fork
			begin
				@(posedge clk);
				rst_n <= 1'b1;
			end
			repeat (20) jtag_master_inst.tick(1'b0, 1'b0, tq);
		join
		@(posedge clk);
		cm_out <= 8'h5a;
		cm_oe <= 8'h3c;
		ch_out <= 8'hc3;
		ch_oe <= 8'h0f;
		cb_out <= 1'b1;
		cb_oe <= 1'b1;
		check_core();
		check(tdo_oe, 1'b0);
		st();
		check(rd[4:3], 2'h0);
		ahb(1'b0, bscan_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h1);
		ahb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		mem_in <= 8'ha5;
		host_in <= 8'h3c;
		mbe_in <= 1'b1;
		addr_in <= 17'h1abcd;
		misc_in <= 28'h9a5c3e1;
		jtag_master_inst.reset5();
		ir(bscan_pkg::IR_SAMPLE);
		check(dout[3:0], 4'h8);
		jtag_master_inst.scan(1'b0, 75, {8'hc6, 67'h0}, dout);
		check(dout[74:8], cells(8'ha5, 8'h3c, 1'b1, 17'h1abcd, 28'h9a5c3e1, 5'h1f));
		check(dout[7:0], 8'hc6);
		ir(bscan_pkg::IR_EXTEST);
		for (int i = 0; i < 4; i++) begin
			d = dirs[i];
			jtag_master_inst.scan(1'b0, 67, {8'h0, cells(8'h96, 8'h69, 1'b1, 17'h0, 28'h0, d)}, dout);
			check(mem_oe, {{4{~d[1]}}, {4{~d[0]}}});
			check(host_oe, {{4{~d[4]}}, {4{~d[3]}}});
			check(mbe_oe, {~d[2]});
			if (d == 5'h00) check({mem_out, host_out, mbe_out}, {8'h96, 8'h69, 1'b1});
		end
		for (int r = 0; r < 2; r++) begin
			if (r == 0) begin
				jtag_master_inst.reset5();
			end else begin
				ir(bscan_pkg::IR_EXTEST);
				jtag_master_inst.scan(1'b0, 67, {8'h0, cells(8'h96, 8'h69, 1'b1, 17'h0, 28'h0, 5'h0)}, dout);
				jtag_master_inst.pulse_trst();
			end
			check_core();
		end
		ir(bscan_pkg::IR_RUNBIST);
		repeat (10) @(posedge clk);
		st();
		check({rd[4], rd[1:0]}, 3'h5);
		for (int t = 0; t < 100 && rd[1] !== 1'b1; t++) st();
		ahb(1'b0, bscan_pkg::REG_BIST_CNT, 32'h0);
		check(rd, BIST_N);
		jtag_master_inst.scan(1'b0, 1, 75'h0, dout);
		check(dout[0], 1'b1);
		ir(bscan_pkg::IR_BYPASS);
		repeat (10) @(posedge clk);
		st();
		check({rd[4], rd[1]}, 2'h0);
		ahb(1'b1, bscan_pkg::REG_CTRL, 32'h0);
		ahb(1'b0, bscan_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h0);
		ir(bscan_pkg::IR_RUNBIST);
		repeat (20) @(posedge clk);
		st();
		check({rd[4], rd[1:0]}, 3'h4);
		ir(bscan_pkg::IR_BYPASS);
		give_verdict();
	end
endmodule
